// ==== verilog/pldsl_top.sv ====
// Purpose: Pin-controlled sleep and state hold for a small PLD core.
// Assumes: Array logic runs on CORE_CLK and honours ARRAY_REG_EN.
// Notes: The shared pin is a sleep pin only when the config bit is set.
// Overview of operation
// [R1] Enabled and pin high enters sleep
// [R2] Sleep freezes outputs and register states
// [R3] Undetermined outputs keep their level
// [R4] Sleep blocks all inputs except sleep pin
// [R5] Sleep ignores clock and input transitions
// [R6] High-impedance outputs stay off in sleep
// [R7] Pin keepers remain active during sleep
// [R8] Sleep works only when configuration asks
// [R9] Dedicated config bit, apart from array
// [R10] Sleep enabled removes pin from array
// [R11] Shared pin macrocell stays otherwise usable
// [R12] Sleep disabled: pin is ordinary input
// [R13] Undriven pins keep previous level
// [R14] Only sleep-requesting configurations set the bit
// [R15] Pin low resumes from held state
`timescale 1ns/10ps
module pldsl_top #(
    parameter int unsigned N_IN = pldsl_pkg::N_IN_DEF,
    parameter int unsigned N_IO = pldsl_pkg::N_IO_DEF
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SRST,
    // Configuration load of the dedicated sleep bit
    input wire logic CFG_LOAD,
    input wire logic CFG_SLEEP_REQ,
    // Shared input or sleep pin
    input wire logic SHARED_INPUT_SLEEP_PIN,
    input wire logic SHARED_EXT_DRV,
    // Dedicated logic input pins
    input wire logic [N_IN-1:0] IN_PIN_I,
    input wire logic [N_IN-1:0] IN_EXT_DRV,
    // Bidirectional pins
    input wire logic [N_IO-1:0] IO_PIN_I,
    input wire logic [N_IO-1:0] IO_EXT_DRV,
    output logic [N_IO-1:0] IO_PIN_O,
    output logic [N_IO-1:0] IO_PIN_OE_N,
    // From the logic array: macrocell results
    input wire logic [N_IO-1:0] ARRAY_OUT,
    input wire logic [N_IO-1:0] ARRAY_OE,
    // To the logic array
    output logic [N_IN-1:0] ARRAY_IN,
    output logic [N_IO-1:0] ARRAY_IO_IN,
    output logic ARRAY_SHARED_TERM,
    output logic ARRAY_REG_EN,
    // Status
    output logic SLEEP_ACTIVE,
    output logic CFG_SLEEP_EN
);
    // Width of the combined pin input path
    localparam int unsigned NP = N_IN + N_IO + 1;

    // All state of the block
    typedef struct packed {
        logic [NP-1:0] s1_r; // First sync stage, read by s2 only
        logic [NP-1:0] s2_r; // Second sync stage
        logic [NP-1:0] s3_r; // Third sync stage
        logic [NP-1:0] filt_r; // Accepted pin levels
        logic cfg_en_r; // Dedicated sleep enable bit
        pldsl_pkg::pldsl_state_t st_r; // Run or sleep
        logic [N_IN-1:0] ain_r; // Inputs presented to array
        logic [N_IO-1:0] aio_r; // I/O feedback presented to array
        logic term_r; // Shared pin as product term
        logic [N_IO-1:0] out_r; // Held output data
        logic [N_IO-1:0] oen_r; // Held output enables, low drives
    } pldsl_core_t;

    pldsl_core_t q;
    pldsl_core_t d;

    // Keeper-resolved pin levels
    logic [N_IN-1:0] in_lvl;
    logic [N_IO-1:0] io_lvl;
    logic sh_lvl;
    logic [NP-1:0] pins_w;
    logic sleep_req; // Sleep wanted on the next edge
    logic [NP-1:0] agree; // Stages two and three agree

    // Keepers on input pins; they have no own buffer
    pldsl_keeper #(
        .W(N_IN)
    ) u_keep_in (
        .clk(CORE_CLK),
        .srst(SRST),
        .pin_i(IN_PIN_I),
        .ext_drv(IN_EXT_DRV),
        .own_o('0),
        .own_oe_n('1),
        .level(in_lvl)
    );

    // Keepers on I/O pins see the held own buffer
    pldsl_keeper #(
        .W(N_IO)
    ) u_keep_io (
        .clk(CORE_CLK),
        .srst(SRST),
        .pin_i(IO_PIN_I),
        .ext_drv(IO_EXT_DRV),
        .own_o(q.out_r),
        .own_oe_n(q.oen_r),
        .level(io_lvl)
    );

    // Keeper on the shared pin, so sleep never sees a floating level
    pldsl_keeper #(
        .W(1)
    ) u_keep_sh (
        .clk(CORE_CLK),
        .srst(SRST),
        .pin_i(SHARED_INPUT_SLEEP_PIN),
        .ext_drv(SHARED_EXT_DRV),
        .own_o(1'h0),
        .own_oe_n(1'h1),
        .level(sh_lvl)
    );

    // Pack pins: shared pin on top, then I/O, then inputs
    assign pins_w = {sh_lvl, io_lvl, in_lvl};
    assign agree = ~(q.s2_r ^ q.s3_r);

    // Sleep needs both the config bit and the accepted pin level
    assign sleep_req = q.cfg_en_r & q.filt_r[NP-1]; // [R1] [R8]

    // Next-state logic
    always_comb begin
        d = q;
        // Synchroniser shifts every edge
        d.s1_r = pins_w;
        d.s2_r = q.s1_r;
        d.s3_r = q.s2_r;
        // Accept a level only once stages two and three agree.
        // The sleep pin bit is accepted even while asleep, so it can wake us.
        d.filt_r[NP-1] = agree[NP-1] ? q.s3_r[NP-1] : q.filt_r[NP-1];
        if (!sleep_req) begin
            // Other inputs frozen while asleep
            d.filt_r[NP-2:0] = (agree[NP-2:0] & q.s3_r[NP-2:0]) |
                (~agree[NP-2:0] & q.filt_r[NP-2:0]); // [R4]
        end
        // Dedicated bit, written only by a configuration load
        if (CFG_LOAD) begin
            d.cfg_en_r = CFG_SLEEP_REQ; // [R9] [R14]
        end
        // State follows the request; waking resumes from held regs
        if (sleep_req) begin
            d.st_r = pldsl_pkg::PLDSL_SLEEP; // [R1]
        end else begin
            d.st_r = pldsl_pkg::PLDSL_RUN; // [R15]
        end
        if (!sleep_req) begin
            // Running: array sees fresh inputs and drives pins
            d.ain_r = q.filt_r[N_IN-1:0];
            d.aio_r = q.filt_r[N_IN+N_IO-1:N_IN];
            // Every macrocell, the shared one too, still drives
            d.out_r = ARRAY_OUT; // [R11]
            d.oen_r = ~ARRAY_OE;
        end
        // Pin joins the array only when sleep is not configured; a bit
        // loaded while asleep masks the term one edge after it is set
        if (q.cfg_en_r) begin
            d.term_r = 1'h0; // [R10]
        end else begin
            d.term_r = q.filt_r[NP-1]; // [R12]
        end
        // Asleep: every held field keeps its value, whatever it is
        // [R2] [R3] [R6]
    end

    // Register state
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            q <= '0;
            q.cfg_en_r <= pldsl_pkg::CFG_SLEEP_RST; // [R8]
            q.st_r <= pldsl_pkg::PLDSL_RUN;
        end else begin
            q <= d;
        end
    end

    // Outputs, all from registers
    assign IO_PIN_O = q.out_r;
    assign IO_PIN_OE_N = q.oen_r;
    assign ARRAY_IN = q.ain_r;
    assign ARRAY_IO_IN = q.aio_r;
    assign ARRAY_SHARED_TERM = q.term_r;
    // Array registers capture only while running
    assign ARRAY_REG_EN = (q.st_r == pldsl_pkg::PLDSL_RUN); // [R5]
    assign SLEEP_ACTIVE = (q.st_r == pldsl_pkg::PLDSL_SLEEP);
    assign CFG_SLEEP_EN = q.cfg_en_r;

    // Pin high, held steady, with the bit set: filter accepts it on the
    // fourth edge, the state register shows sleep one edge after that
    sequence s_pin_high;
        (q.cfg_en_r && sh_lvl) [*4];
    endsequence
    property p_enter;
        @(posedge CORE_CLK) disable iff (SRST)
        (s_pin_high ##0 (!CFG_LOAD && q.cfg_en_r)) |=> ##1 SLEEP_ACTIVE;
    endproperty
    a_enter: assert property (p_enter) // [R1]
        else $error("Sleep not entered after pin held high");

    // Data outputs keep their value across a sleep edge
    property p_hold_out;
        @(posedge CORE_CLK) disable iff (SRST)
        (SLEEP_ACTIVE && $past(SLEEP_ACTIVE)) |->
            (IO_PIN_O == $past(IO_PIN_O));
    endproperty
    a_hold_out: assert property (p_hold_out) // [R2]
        else $error("Output data changed during sleep");

    // Disabled outputs remain disabled through sleep
    property p_hold_oe;
        @(posedge CORE_CLK) disable iff (SRST)
        (SLEEP_ACTIVE && $past(SLEEP_ACTIVE)) |->
            (IO_PIN_OE_N == $past(IO_PIN_OE_N));
    endproperty
    a_hold_oe: assert property (p_hold_oe) // [R6]
        else $error("Output enable changed during sleep");

    // No input reaches the array while asleep
    property p_block_in;
        @(posedge CORE_CLK) disable iff (SRST)
        (SLEEP_ACTIVE && $past(SLEEP_ACTIVE)) |->
            (ARRAY_IN == $past(ARRAY_IN) &&
             ARRAY_IO_IN == $past(ARRAY_IO_IN));
    endproperty
    a_block_in: assert property (p_block_in) // [R4]
        else $error("Input reached array during sleep");

    // Register enable is exactly the inverse of sleep
    property p_regen;
        @(posedge CORE_CLK) disable iff (SRST)
        ARRAY_REG_EN != SLEEP_ACTIVE;
    endproperty
    a_regen: assert property (p_regen) // [R5]
        else $error("Array register enable active in sleep");

    // With the enable low the pin outputs, enables and array input buses do not move
    property p_capture_stop;
        @(posedge CORE_CLK) disable iff (SRST)
        !ARRAY_REG_EN |->
            ($stable(IO_PIN_O) && $stable(IO_PIN_OE_N) &&
             $stable(ARRAY_IN) && $stable(ARRAY_IO_IN));
    endproperty
    a_capture_stop: assert property (p_capture_stop) // [R5]
        else $error("Block state captured while clock ignored");

    // Running, outputs follow the array one edge later
    property p_follow;
        @(posedge CORE_CLK) disable iff (SRST)
        (ARRAY_REG_EN && !$past(SRST)) |->
            (IO_PIN_O == $past(ARRAY_OUT) &&
             IO_PIN_OE_N == ~$past(ARRAY_OE));
    endproperty
    a_follow: assert property (p_follow) // [R15]
        else $error("Outputs not following array while running");

    // A configuration load writes the dedicated bit on the next edge
    property p_cfg_load;
        @(posedge CORE_CLK) disable iff (SRST)
        CFG_LOAD |=> (CFG_SLEEP_EN == $past(CFG_SLEEP_REQ));
    endproperty
    a_cfg_load: assert property (p_cfg_load) // [R9]
        else $error("Sleep bit not written by configuration load");

    // Without the bit, sleep is never entered
    property p_cfg_off;
        @(posedge CORE_CLK) disable iff (SRST)
        (!CFG_SLEEP_EN && $past(!CFG_SLEEP_EN)) |=> !SLEEP_ACTIVE;
    endproperty
    a_cfg_off: assert property (p_cfg_off) // [R8]
        else $error("Sleep entered with feature disabled");

    // Shared pin is no product term once sleep is configured
    property p_term_masked;
        @(posedge CORE_CLK) disable iff (SRST)
        (CFG_SLEEP_EN && $past(CFG_SLEEP_EN)) |-> !ARRAY_SHARED_TERM;
    endproperty
    a_term_masked: assert property (p_term_masked) // [R10]
        else $error("Shared pin fed array with sleep enabled");

    // Unconfigured, the term follows the pin after the sync path
    property p_term_plain;
        @(posedge CORE_CLK) disable iff (SRST)
        (!CFG_SLEEP_EN && !CFG_LOAD && sh_lvl) [*6] |->
            ARRAY_SHARED_TERM;
    endproperty
    a_term_plain: assert property (p_term_plain) // [R12]
        else $error("Shared pin not seen as ordinary input");

    // Pin held low wakes the block within the sync latency
    sequence s_pin_low;
        !sh_lvl [*4];
    endsequence
    property p_wake;
        @(posedge CORE_CLK) disable iff (SRST)
        s_pin_low |=> ##1 !SLEEP_ACTIVE;
    endproperty
    a_wake: assert property (p_wake) // [R15]
        else $error("Sleep not left after pin returned low");
endmodule

// ==== verilog/pldsl_pkg.sv ====
// Purpose: Shared constants for the sleep-hold block of a small PLD.
// Assumes: One core clock, synchronous active-high reset.
// Notes: Pin counts are defaults only; the top module takes parameters.
package pldsl_pkg;
    // Default pin counts of the device model
    localparam int unsigned N_IN_DEF = 11;
    localparam int unsigned N_IO_DEF = 10;
    // Depth of the pin input synchroniser
    localparam int unsigned SYNC_DEPTH = 3;
    // Reset value of the dedicated sleep enable bit: feature off
    localparam logic CFG_SLEEP_RST = 1'h0;
    // Edges from a sleep pin change to the filter accepting it; the held state takes effect one edge later
    localparam int unsigned SLEEP_LAT = 4;
    // Operating states of the hold logic
    typedef enum logic {PLDSL_RUN, PLDSL_SLEEP} pldsl_state_t;
endpackage

// ==== verilog/pldsl_keeper.sv ====
// Purpose: Pin keepers that hold each pin at its last driven level.
// Assumes: Each pin reports whether the board drives it; outputs known.
// Notes: Keepers stay active in sleep, so pins never float.
`timescale 1ns/10ps
module pldsl_keeper #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Pin side
    input wire logic [W-1:0] pin_i,
    input wire logic [W-1:0] ext_drv,
    // Own output buffer of each pin
    input wire logic [W-1:0] own_o,
    input wire logic [W-1:0] own_oe_n,
    // Resolved level seen by the input path
    output logic [W-1:0] level
);
    // All keeper state
    typedef struct packed {
        logic [W-1:0] last_r;
    } pldsl_keep_t;

    pldsl_keep_t q;
    pldsl_keep_t d;
    logic [W-1:0] lvl_w;

    // One keeper per pin: external driver, else own buffer, else last
    genvar gi;
    generate
        for (gi = 0; gi < W; gi = gi + 1) begin : g_keep
            always_comb begin
                if (ext_drv[gi]) begin
                    lvl_w[gi] = pin_i[gi];
                end else if (!own_oe_n[gi]) begin
                    lvl_w[gi] = own_o[gi];
                end else begin
                    lvl_w[gi] = q.last_r[gi]; // [R13] [R7]
                end
            end
        end
    endgenerate

    assign level = lvl_w;

    // Next state: remember whatever the pin resolved to
    always_comb begin
        d = q;
        d.last_r = lvl_w;
    end

    // Register state
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Undriven pin 0 keeps the level it had one edge before
    property p_keep_hold;
        @(posedge clk) disable iff (srst)
        (~ext_drv[0] & own_oe_n[0]) |-> (level[0] == $past(level[0]));
    endproperty
    a_keep_hold: assert property (p_keep_hold) // [R13]
        else $error("Undriven pin lost its kept level");
endmodule

// ==== dv/pldsl_board.sv ====
// Purpose: Board logic that drives the shared sleep pin.
// Assumes: Commands are sampled on the rising clock edge.
// Notes: A released pin shows the inverse of its last level.
`timescale 1ns/10ps
module pldsl_board (
    // Clock
    input wire logic clk,
    // Commands from the bench
    input wire logic want_sleep,
    input wire logic drive,
    // Shared pin as seen by the device
    output logic pin,
    output logic ext_drv
);
    // Last level the board put on the pin
    logic last_r;
    // Drive the request; once released, show a wrong level on purpose
    always @(posedge clk) begin
        if (drive) begin
            pin <= want_sleep;
            last_r <= want_sleep;
        end else begin
            pin <= ~last_r; // Only the keeper can hide this
        end
        ext_drv <= drive;
    end
    // Known levels from time zero
    initial begin
        pin = 1'h0;
        last_r = 1'h0;
        ext_drv = 1'h1;
    end
endmodule

// ==== dv/pldsl_top_test.sv ====
// Purpose: Self-checking bench of the sleep-hold block.
// Assumes: Default pin counts; inputs change 1 ns after the edge.
// Notes: Undriven pins show inverted levels so keepers are exercised.
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin checks++; \
    if ((got) !== (exp)) begin err_count++; \
    $display("mismatch at %0t: %s", $time, msg); end end
module pldsl_top_test;
    // Clock, reset, configuration and board commands
    logic clk, srst, cfg_load, cfg_req, want, drv;
    // Shared pin from the board model
    logic sh_pin, sh_ext;
    // Input and I/O pins, array results
    logic [10:0] in_val, in_ext, in_pin;
    logic [9:0] io_val, io_ext, io_pin, a_out, a_oe;
    // Outputs of the block
    logic [9:0] io_o, io_oe_n, a_io_in;
    logic [10:0] a_in;
    logic term, reg_en, sleep, cfg_en;
    int err_count = 0;
    int checks = 0;
    // Undriven pins show the inverse; I/O wire follows own buffer
    assign in_pin = in_val ~^ in_ext;
    assign io_pin = (io_ext & io_val) | (~io_ext & ~io_oe_n & io_o)
        | (~io_ext & io_oe_n & ~io_val);
    pldsl_top u_pldsl_top (.CORE_CLK(clk), .SRST(srst),
        .CFG_LOAD(cfg_load), .CFG_SLEEP_REQ(cfg_req),
        .SHARED_INPUT_SLEEP_PIN(sh_pin), .SHARED_EXT_DRV(sh_ext),
        .IN_PIN_I(in_pin), .IN_EXT_DRV(in_ext), .IO_PIN_I(io_pin),
        .IO_EXT_DRV(io_ext), .IO_PIN_O(io_o), .IO_PIN_OE_N(io_oe_n),
        .ARRAY_OUT(a_out), .ARRAY_OE(a_oe), .ARRAY_IN(a_in),
        .ARRAY_IO_IN(a_io_in), .ARRAY_SHARED_TERM(term),
        .ARRAY_REG_EN(reg_en), .SLEEP_ACTIVE(sleep), .CFG_SLEEP_EN(cfg_en));
    pldsl_board u_pldsl_board (.clk(clk), .want_sleep(want), .drive(drv),
        .pin(sh_pin), .ext_drv(sh_ext));
    // Free-running 250 MHz clock
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // Step n edges, then land just after the last one
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Bounded wait for the sleep status; a hang ends the run
    task automatic wait_sleep(input logic lvl);
        int n;
        n = 0;
        while (sleep !== lvl && n < 12) begin
            step(1);
            n++;
        end
        if (sleep !== lvl) begin
            err_count++;
            $display("mismatch at %0t: sleep wait timed out", $time);
            end_of_test();
        end
    endtask
    // Feature off: pin high is a plain array input
    task automatic t_disabled();
        want = 1'h1;
        step(10);
        `CHK(sleep, 1'h0, "sleep while disabled")
        `CHK(reg_en, 1'h1, "regs stopped while disabled")
        `CHK(term, 1'h1, "term not high")
        want = 1'h0;
        step(10);
        `CHK(term, 1'h0, "term not low")
        $display("done disabled");
    endtask
    // Load the dedicated sleep bit
    task automatic t_config();
        cfg_load = 1'h1;
        cfg_req = 1'h1;
        step(1);
        cfg_load = 1'h0;
        step(2);
        `CHK(cfg_en, 1'h1, "sleep bit not set")
        $display("done config");
    endtask
    // Enter sleep, disturb array results and input pins, then wake
    task automatic t_sleep();
        a_out = 10'h2a5;
        a_oe = 10'h0f0;
        in_val = 11'h555;
        step(10);
        want = 1'h1;
        wait_sleep(1'h1);
        a_out = 10'h15a;
        a_oe = 10'h3ff;
        in_val = 11'h2aa;
        step(12);
        `CHK(reg_en, 1'h0, "regs run in sleep")
        `CHK(io_o, 10'h2a5, "output moved")
        `CHK(io_oe_n, 10'h30f, "enable moved")
        `CHK(a_in, 11'h555, "input passed")
        `CHK(term, 1'h0, "pin reached array")
        want = 1'h0;
        wait_sleep(1'h0);
        step(8);
        `CHK(reg_en, 1'h1, "regs still stopped")
        `CHK(io_o, 10'h15a, "output not resumed")
        `CHK(io_oe_n, 10'h000, "enable not resumed")
        `CHK(a_in, 11'h2aa, "input not resumed")
        $display("done sleep");
    endtask
    // Released input and shared pins keep their last level; I/O pins follow own buffer
    task automatic t_keeper();
        in_val = 11'h7f0;
        step(8);
        in_ext = 11'h000;
        io_ext = 10'h000;
        a_out = 10'h1c3;
        drv = 1'h0;
        step(12);
        `CHK(a_in, 11'h7f0, "input keeper lost level")
        `CHK(a_io_in, 10'h1c3, "feedback lost")
        `CHK(sleep, 1'h0, "floating pin slept")
        cfg_load = 1'h1;
        cfg_req = 1'h0;
        step(1);
        cfg_load = 1'h0;
        `CHK(cfg_en, 1'h0, "bit set by plain config")
        $display("done keeper");
    endtask
    // Main sequence
    initial begin
        srst = 1'h1;
        cfg_load = 1'h0;
        cfg_req = 1'h0;
        want = 1'h0;
        drv = 1'h1;
        in_val = 11'h000;
        in_ext = 11'h7ff;
        io_val = 10'h000;
        io_ext = 10'h3ff;
        a_out = 10'h000;
        a_oe = 10'h000;
        step(2);
        srst = 1'h0;
        `CHK(io_oe_n, 10'h000, "enable reset value")
        step(1);
        `CHK(cfg_en, 1'h0, "sleep bit not clear")
        `CHK(sleep, 1'h0, "asleep after reset")
        `CHK(io_oe_n, 10'h3ff, "enable not following array")
        $display("done reset");
        t_disabled();
        t_config();
        t_sleep();
        t_keeper();
        end_of_test();
    end
endmodule
